/* isa_host_bus_interface.sv */
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/100ps
module isa_host_bus_interface
  import isa_host_bus_pkg::*;
#(
  parameter int IO_WORDS = 32,
  parameter logic [23:0] IO_BASE = 24'h0003c0,
  parameter logic [23:0] MEM_BASE = 24'h0a0000,
  parameter logic [23:0] MEM_LIMIT = 24'h0bffff
)(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // APB slave
  input wire apb_req_t apb_req,
  output apb_rsp_t apb_rsp,
  // ISA pins, asynchronous
  input wire isa_pins_t pins,
  output logic [15:0] host_data_out,
  output logic host_data_oe,
  output logic ready_oe,
  output logic zero_wait_oe,
  output logic irq_out,
  output logic irq_oe,
  // Display memory data pins
  output logic [15:0] display_mem_data_out,
  output logic display_mem_data_oe,
  // Core side, same clock
  input wire logic vretrace_evt,
  input wire logic vretrace_clr,
  input wire logic seq_reset,
  input wire logic md_drive_req,
  input wire logic [15:0] md_wdata,
  input wire logic cpu_mem_grant,
  input wire logic cpu_mem_done,
  input wire logic [15:0] cpu_mem_rdata,
  output logic cpu_mem_req,
  output logic cpu_mem_we,
  output logic [23:0] cpu_mem_addr,
  output logic [15:0] cpu_mem_wdata,
  output logic [2:0] psave_mode,
  output logic hw_suspend
);
  localparam int IDX_W = $clog2(IO_WORDS);

  typedef struct packed {
    isa_pins_t p1;
    isa_pins_t p2;
    logic rst_prev;
    logic [21:0] alat_addr;
    logic [7:0] aux_cfg;
    logic [6:0] straps;
    logic [CTRL_W-1:0] ctrl;
    logic irq_flag;
    logic irq_out;
    logic irq_oe;
    cyc_state_t cyc;
    logic [15:0] dout;
    logic dout_oe;
    logic ready_oe;
    logic zws_oe;
    logic [7:0] wbyte;
    logic [IDX_W-1:0] widx;
    logic mreq;
    logic mwe;
    logic [23:0] maddr;
    logic [15:0] mwdata;
    logic [15:0] md_out;
    logic md_oe;
    logic [2:0] psave;
    logic susp;
    apb_rsp_t rsp;
    logic [IO_WORDS-1:0][7:0] io_regs;
  } state_t;

  state_t s;
  state_t n;

  // I/O window hit
  function automatic logic io_hit(input logic [23:0] a);
    io_hit = (a >= IO_BASE) && (a < IO_BASE + 24'(IO_WORDS));
  endfunction : io_hit

  // Display memory window hit
  function automatic logic mem_hit(input logic [23:0] a);
    mem_hit = (a >= MEM_BASE) && (a <= MEM_LIMIT);
  endfunction : mem_hit

  logic susp;
  logic hr;
  logic alat_on;
  logic [23:0] addr;
  logic [15:0] wdat;
  logic io_en;
  logic mem_en;
  logic [IDX_W-1:0] idx;
  logic apb_acc;

  // Qualified pin views
  always_comb
  begin
    susp = ~s.p2.suspend_n;
    hr = s.p2.host_reset & ~susp;
    alat_on = s.straps[S_ALAT] & s.straps[S_GATE];
    addr = susp ? 24'h000000 : (alat_on ? {s.alat_addr, s.p2.addr[1:0]} : s.p2.addr);
    wdat = susp ? 16'h0000 : s.p2.data;
    io_en = ~susp & ~hr & ~s.p2.io_decode_gate;
    mem_en = ~susp & ~hr & s.p2.host_refresh_gate;
    idx = IDX_W'(addr - IO_BASE);
    apb_acc = apb_req.psel & apb_req.penable;
  end

  // Next state
  always_comb
  begin
    n = s;
    n.p1 = pins;
    n.p2 = s.p1;
    n.rst_prev = s.p2.host_reset;
    n.susp = susp;
    n.psave = susp ? PS_SUSPEND : s.ctrl[C_PS_LSB +: 3];
    // Upper address follows the pins while ALE is high, held while it is low
    if (alat_on && !susp && s.p2.ale)
      n.alat_addr = s.p2.addr[23:2];
    // Straps caught on the falling reset edge
    if (s.rst_prev && !s.p2.host_reset && !susp)
    begin
      n.aux_cfg = {s.p2.display_mem_data[12:9], s.p2.display_mem_data[3:0]};
      n.straps = {s.p2.display_mem_data[14:13], s.p2.display_mem_data[8:4]};
    end
    // Display memory data drivers
    n.md_out = md_wdata;
    n.md_oe = md_drive_req & ~s.p2.host_reset & ~seq_reset;
    // Retrace interrupt, set beats clear
    if (vretrace_evt && s.ctrl[C_IRQ_EN])
      n.irq_flag = 1'b1;
    else if (vretrace_clr)
      n.irq_flag = 1'b0;
    n.irq_out = s.irq_flag;
    n.irq_oe = s.ctrl[C_IRQ_OE] & ~susp;
    // Host cycle sequencing
    case (s.cyc)
      ST_IDLE:
      begin
        if (io_en && io_hit(addr) && !s.p2.ior_n)
        begin
          n.cyc = ST_IO_RD;
          n.dout = {s.io_regs[idx], s.io_regs[idx]};
          n.dout_oe = 1'b1;
          n.zws_oe = 1'b1;
        end
        else if (io_en && io_hit(addr) && !s.p2.iow_n)
        begin
          n.cyc = ST_IO_WR;
          n.widx = idx;
          n.wbyte = wdat[7:0];
          n.zws_oe = 1'b1;
        end
        else if (mem_en && mem_hit(addr) && !(s.p2.memr_n && s.p2.memw_n))
        begin
          n.cyc = ST_MEM_WAIT;
          n.ready_oe = 1'b1;
          n.mreq = 1'b1;
          n.mwe = ~s.p2.memw_n;
          n.maddr = addr;
          n.mwdata = s.p2.bhe_n ? {8'h00, wdat[7:0]} : wdat;
        end
      end
      ST_IO_RD:
      begin
        if (s.p2.ior_n)
        begin
          n.cyc = ST_IDLE;
          n.dout_oe = 1'b0;
          n.zws_oe = 1'b0;
        end
      end
      ST_IO_WR:
      begin
        if (!s.p2.iow_n)
          n.wbyte = wdat[7:0];
        else
        begin
          n.io_regs[s.widx] = s.wbyte;
          n.cyc = ST_IDLE;
          n.zws_oe = 1'b0;
        end
      end
      ST_MEM_WAIT:
      begin
        if (cpu_mem_grant && cpu_mem_done)
        begin
          n.mreq = 1'b0;
          n.ready_oe = 1'b0;
          n.dout = cpu_mem_rdata;
          n.dout_oe = ~s.mwe;
          n.cyc = ST_MEM_END;
        end
      end
      ST_MEM_END:
      begin
        if (s.p2.memr_n && s.p2.memw_n)
        begin
          n.dout_oe = 1'b0;
          n.cyc = ST_IDLE;
        end
      end
      default:
      begin
        n.cyc = ST_IDLE;
      end
    endcase
    // Suspend or host reset drops every host output
    if (susp || hr)
    begin
      n.cyc = ST_IDLE;
      n.dout_oe = 1'b0;
      n.ready_oe = 1'b0;
      n.zws_oe = 1'b0;
      n.mreq = 1'b0;
    end
    // Host reset clears the register state
    if (hr)
    begin
      n.ctrl = CTRL_RESET;
      n.irq_flag = 1'b0;
      n.irq_oe = 1'b0;
      n.io_regs = '0;
      n.alat_addr = '0;
    end
    // APB slave, one wait cycle per access
    n.rsp.pready = apb_acc & ~s.rsp.pready;
    n.rsp.pslverr = 1'b0;
    n.rsp.prdata = 32'h00000000;
    if (apb_acc && !s.rsp.pready)
    begin
      if (apb_req.paddr == A_AUX_CFG)
        n.rsp.prdata = {24'h000000, s.aux_cfg};
      else if (apb_req.paddr == A_STRAPS)
        n.rsp.prdata = {25'h0000000, s.straps};
      else if (apb_req.paddr == A_CTRL)
        n.rsp.prdata = {27'h0000000, s.ctrl};
      else if (apb_req.paddr == A_STATUS)
        n.rsp.prdata = {24'h000000, s.cyc, alat_on, s.irq_flag, susp};
      else
        n.rsp.pslverr = 1'b1;
    end
    // Control write lands on the completing edge
    if (apb_acc && s.rsp.pready && apb_req.pwrite && apb_req.paddr == A_CTRL && !hr)
      n.ctrl = apb_req.pwdata[CTRL_W-1:0];
  end

  // State register
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      s <= '0;
      s.p1 <= PINS_IDLE;
      s.p2 <= PINS_IDLE;
      s.cyc <= ST_IDLE;
      s.ctrl <= CTRL_RESET;
      s.aux_cfg <= AUX_RESET;
      s.straps <= STRAPS_RESET;
    end
    else
      s <= n;
  end

  // Outputs from flops
  assign apb_rsp = s.rsp;
  assign host_data_out = s.dout;
  assign host_data_oe = s.dout_oe;
  assign ready_oe = s.ready_oe;
  assign zero_wait_oe = s.zws_oe;
  assign irq_out = s.irq_out;
  assign irq_oe = s.irq_oe;
  assign display_mem_data_out = s.md_out;
  assign display_mem_data_oe = s.md_oe;
  assign cpu_mem_req = s.mreq;
  assign cpu_mem_we = s.mwe;
  assign cpu_mem_addr = s.maddr;
  assign cpu_mem_wdata = s.mwdata;
  assign psave_mode = s.psave;
  assign hw_suspend = s.susp;

  // Checks
  a_md_hiz_reset: assert property (@(posedge mclk) disable iff (sys_rst)
    (s.p2.host_reset || seq_reset) |=> !display_mem_data_oe)
    else $error("memory data driven during reset");
  a_strap_capture: assert property (@(posedge mclk) disable iff (sys_rst)
    (s.rst_prev && !s.p2.host_reset && !susp) |=>
    s.aux_cfg == {$past(s.p2.display_mem_data[12:9]), $past(s.p2.display_mem_data[3:0])})
    else $error("aux strap not captured");
  a_alat_gated: assert property (@(posedge mclk) disable iff (sys_rst)
    !s.straps[S_GATE] |-> !alat_on)
    else $error("address latch active without gate strap");
  a_data_claimed: assert property (@(posedge mclk) disable iff (sys_rst)
    host_data_oe |-> (s.cyc == ST_IO_RD || s.cyc == ST_MEM_END))
    else $error("host data driven outside a claimed read");
  a_susp_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
    susp |=> (s.cyc == ST_IDLE && !ready_oe && !zero_wait_oe && !host_data_oe))
    else $error("host cycle claimed in suspend");
  a_refresh_gate: assert property (@(posedge mclk) disable iff (sys_rst)
    (s.cyc == ST_IDLE && !s.p2.host_refresh_gate) |=> !ready_oe)
    else $error("memory claimed during refresh");
  a_io_gate: assert property (@(posedge mclk) disable iff (sys_rst)
    (s.cyc == ST_IDLE && s.p2.io_decode_gate) |=> !zero_wait_oe)
    else $error("io claimed with decode gate high");
  a_ready_release: assert property (@(posedge mclk) disable iff (sys_rst)
    (s.cyc == ST_MEM_WAIT && cpu_mem_grant && cpu_mem_done) |=> !ready_oe ##0 !cpu_mem_req)
    else $error("ready not released after transfer");
  a_irq_sticky: assert property (@(posedge mclk) disable iff (sys_rst)
    (s.irq_flag && !vretrace_clr && !hr) |=> s.irq_flag ##1 irq_out)
    else $error("interrupt dropped without clear");
  a_irq_tristate: assert property (@(posedge mclk) disable iff (sys_rst)
    !s.ctrl[C_IRQ_OE] |=> !irq_oe)
    else $error("interrupt driven while disabled");
  a_susp_override: assert property (@(posedge mclk) disable iff (sys_rst)
    susp |=> psave_mode == PS_SUSPEND)
    else $error("suspend did not override power save");
  a_apb_answer: assert property (@(posedge mclk) disable iff (sys_rst)
    (apb_acc && !apb_rsp.pready) |=> apb_rsp.pready)
    else $error("apb answer late");
  a_irq_rise: assert property (@(posedge mclk) disable iff (sys_rst)
    (vretrace_evt && s.ctrl[C_IRQ_EN] && !hr) |=> s.irq_flag ##1 irq_out)
    else $error("retrace interrupt did not rise");
  a_zws_claim: assert property (@(posedge mclk) disable iff (sys_rst)
    zero_wait_oe |-> (s.cyc == ST_IO_RD || s.cyc == ST_IO_WR))
    else $error("zero wait driven outside a claimed io cycle");
  a_ready_claim: assert property (@(posedge mclk) disable iff (sys_rst)
    ready_oe |-> s.cyc == ST_MEM_WAIT)
    else $error("ready held low outside a memory wait");
  a_ready_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    (s.cyc == ST_MEM_WAIT && !(cpu_mem_grant && cpu_mem_done) && !susp && !hr) |=> ready_oe)
    else $error("ready released before transfer done");
  a_hr_clears: assert property (@(posedge mclk) disable iff (sys_rst)
    hr |=> (s.ctrl == CTRL_RESET && !s.irq_flag && !irq_oe))
    else $error("host reset left register state");
  a_straps_fixed: assert property (@(posedge mclk) disable iff (sys_rst)
    !(s.rst_prev && !s.p2.host_reset && !susp) |=> $stable(s.straps))
    else $error("straps changed outside reset edge");
  a_regs_frozen: assert property (@(posedge mclk) disable iff (sys_rst)
    (susp && s.cyc == ST_IDLE) |=> $stable(s.io_regs))
    else $error("io register written in suspend");
endmodule : isa_host_bus_interface

/* isa_host_bus_pkg.sv */
// What this block does
// - Display memory data drivers off during resets
// - Reset fall captures pins 3:0,12:9 read-only
// - Reset fall fixes option straps until reset
// - Address-latch strap latches upper address on ALE
// - Address-latch strap needs gate strap bit 0 (pin 4) set
// - Drive host data only on claimed reads
// - Suspend masks host address inputs
// - Suspend masks host data inputs
// - Refresh gate low disables memory decode
// - I/O gate high disables I/O decode
// - Suspend ignores all host strobes and gates, except a claimed I/O write strobe ending in the first suspended cycle
// - READY low for waits, released after transfer
// - Host reset clears registers, outputs inactive
// - Host reset ignored during suspend, except by the display memory data drivers
// - Suspend pin overrides software power save
// - Enabled retrace interrupt rises zero to one
// - Interrupt held until timing controller clears it
// - Interrupt output tri-stated when disabled
// - Zero-wait output low on claimed I/O
package isa_host_bus_pkg;
  // APB byte addresses
  localparam logic [7:0] A_AUX_CFG = 8'h00;
  localparam logic [7:0] A_STRAPS = 8'h04;
  localparam logic [7:0] A_CTRL = 8'h08;
  localparam logic [7:0] A_STATUS = 8'h0c;
  // Control fields
  localparam int CTRL_W = 5;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam int C_IRQ_EN = 0;
  localparam int C_IRQ_OE = 1;
  localparam int C_PS_LSB = 2;
  // Power save codes
  localparam logic [2:0] PS_SUSPEND = 3'h7;
  // Strap positions within the 7-bit strap word {md[14:13], md[8:4]}
  localparam int S_GATE = 0;
  localparam int S_ALAT = 1;
  localparam logic [6:0] STRAPS_RESET = 7'h00;
  localparam logic [7:0] AUX_RESET = 8'h00;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_IO_RD = 5'h02,
    ST_IO_WR = 5'h04,
    ST_MEM_WAIT = 5'h08,
    ST_MEM_END = 5'h10
  } cyc_state_t;

  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] data;
    logic ior_n;
    logic iow_n;
    logic memr_n;
    logic memw_n;
    logic bhe_n;
    logic ale;
    logic io_decode_gate;
    logic host_refresh_gate;
    logic host_reset;
    logic suspend_n;
    logic [15:0] display_mem_data;
  } isa_pins_t;

  // Idle bus levels, so the synchroniser shows no strobe or suspend after reset
  localparam isa_pins_t PINS_IDLE = '{ior_n: 1'b1, iow_n: 1'b1, memr_n: 1'b1, memw_n: 1'b1,
    bhe_n: 1'b1, host_refresh_gate: 1'b1, suspend_n: 1'b1, default: '0};

  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;
endpackage : isa_host_bus_pkg

/* isa_host_model.sv */
`timescale 1ns/100ps
module isa_host_model
  import isa_host_bus_pkg::*;
#(
  parameter logic [15:0] MEM_WORD = 16'hc3a5
)(
  // Clock
  input wire logic mclk,
  // ISA bus side
  output isa_pins_t pins,
  input wire logic [15:0] host_data_out,
  input wire logic host_data_oe,
  input wire logic ready_oe,
  input wire logic zero_wait_oe,
  // Display memory arbiter side
  input wire logic cpu_mem_req,
  output logic cpu_mem_grant,
  output logic cpu_mem_done,
  output logic [15:0] cpu_mem_rdata
);
  int wait_n = 0;
  int cnt = 0;
  logic drv = 1'b0;

  // Idle bus: strobes off, gates open, arbiter quiet
  initial
  begin
    pins = '0;
    {pins.ior_n, pins.iow_n, pins.memr_n, pins.memw_n, pins.bhe_n} = 5'h1f;
    pins.host_refresh_gate = 1'b1;
    pins.suspend_n = 1'b1;
    cpu_mem_grant = 1'b0;
    cpu_mem_done = 1'b0;
    cpu_mem_rdata = 16'h0;
  end

  // Grant after wait_n request cycles; undriven lines keep changing
  always @(posedge mclk)
  begin
    cnt <= cpu_mem_req ? cnt + 1 : 0;
    cpu_mem_grant <= cpu_mem_req && cnt >= wait_n;
    cpu_mem_done <= cpu_mem_req && cnt >= wait_n;
    cpu_mem_rdata <= (cpu_mem_req && cnt >= wait_n) ? MEM_WORD : ~cpu_mem_rdata;
    if (!drv)
      pins.data <= ~pins.data;
  end

  // Host cycle: kind 0 io read, 1 io write, 2 mem read, 3 mem write
  task automatic cycle(input int kind, input logic [23:0] a, input logic [15:0] d,
                       output logic [15:0] q, output logic claimed, output int n_ready);
    q = 16'h0;
    claimed = 1'b0;
    n_ready = 0;
    @(posedge mclk);
    pins.addr <= a;
    drv <= kind[0];
    @(posedge mclk);
    if (kind[0])
      pins.data <= d;
    pins.ior_n <= (kind != 0);
    pins.iow_n <= (kind != 1);
    pins.memr_n <= (kind != 2);
    pins.memw_n <= (kind != 3);
    repeat (24)
    begin
      @(posedge mclk);
      claimed = claimed | ((kind < 2) ? zero_wait_oe : ready_oe);
      n_ready += ready_oe;
      if (host_data_oe === 1'b1)
        q = host_data_out;
    end
    {pins.ior_n, pins.iow_n, pins.memr_n, pins.memw_n} <= 4'hf;
    drv <= 1'b0;
    repeat (5) @(posedge mclk);
  endtask : cycle
endmodule : isa_host_model

/* isa_host_bus_interface_test.sv */
`timescale 1ns/100ps
module isa_host_bus_interface_test
  import isa_host_bus_pkg::*;
;
  localparam logic [23:0] IO_B = 24'h0003c0;
  localparam logic [23:0] MEM_B = 24'h0a0000;
  localparam logic [23:0] MEM_L = 24'h0bffff;
  localparam logic [15:0] MW = 16'hc3a5;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  apb_req_t apb_req = '0;
  apb_rsp_t apb_rsp;
  isa_pins_t pins;
  logic [15:0] host_data_out, display_mem_data_out, cpu_mem_rdata, cpu_mem_wdata;
  logic [15:0] md_wdata = 16'h6b2d;
  logic host_data_oe, ready_oe, zero_wait_oe, irq_out, irq_oe, display_mem_data_oe;
  logic vretrace_evt = 1'b0, vretrace_clr = 1'b0, seq_reset = 1'b0, md_drive_req = 1'b0;
  logic cpu_mem_grant, cpu_mem_done, cpu_mem_req, cpu_mem_we, hw_suspend;
  logic [23:0] cpu_mem_addr;
  logic [2:0] psave_mode;
  int n_fail = 0, samples_checked = 0, cycles = 0, nr;
  logic [31:0] rd;
  logic er, cl;
  logic [15:0] q;
  logic [15:0] mds [2] = '{16'h5a3c, 16'h0020};

  // Device and host
  isa_host_bus_interface #(.IO_BASE(IO_B), .MEM_BASE(MEM_B), .MEM_LIMIT(MEM_L)) dut_u (
    .mclk(mclk), .sys_rst(sys_rst), .apb_req(apb_req), .apb_rsp(apb_rsp), .pins(pins),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe), .ready_oe(ready_oe),
    .zero_wait_oe(zero_wait_oe), .irq_out(irq_out), .irq_oe(irq_oe),
    .display_mem_data_out(display_mem_data_out), .display_mem_data_oe(display_mem_data_oe),
    .vretrace_evt(vretrace_evt), .vretrace_clr(vretrace_clr), .seq_reset(seq_reset),
    .md_drive_req(md_drive_req), .md_wdata(md_wdata), .cpu_mem_grant(cpu_mem_grant),
    .cpu_mem_done(cpu_mem_done), .cpu_mem_rdata(cpu_mem_rdata), .cpu_mem_req(cpu_mem_req),
    .cpu_mem_we(cpu_mem_we), .cpu_mem_addr(cpu_mem_addr), .cpu_mem_wdata(cpu_mem_wdata),
    .psave_mode(psave_mode), .hw_suspend(hw_suspend));
  isa_host_model #(.MEM_WORD(MW)) host_u (
    .mclk(mclk), .pins(pins), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
    .ready_oe(ready_oe), .zero_wait_oe(zero_wait_oe), .cpu_mem_req(cpu_mem_req),
    .cpu_mem_grant(cpu_mem_grant), .cpu_mem_done(cpu_mem_done), .cpu_mem_rdata(cpu_mem_rdata));

  // Clock and hang guard
  initial
  begin
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      complete_run();
    end
  end

  // Result checks
  task automatic cmp_word(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp_word
  task automatic cmp_bit(input string nm, input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL %s expected %b seen %b", nm, exp, got);
    end
  endtask : cmp_bit

  // APB transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdv, output logic err);
    @(posedge mclk);
    apb_req <= '{a, 1'b1, 1'b0, wr, wd};
    @(posedge mclk);
    apb_req.penable <= 1'b1;
    @(posedge mclk);
    while (apb_rsp.pready !== 1'b1)
      @(posedge mclk);
    rdv = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
  endtask : apb
  task automatic reg_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, rd, er);
    cmp_word("reg", rd, e);
  endtask : reg_chk

  // Host reset pulse with straps on the memory data pins
  task automatic hreset(input logic [15:0] v);
    @(posedge mclk);
    host_u.pins.display_mem_data <= v;
    host_u.pins.host_reset <= 1'b1;
    repeat (5) @(posedge mclk);
    cmp_bit("md_oe_rst", display_mem_data_oe, 1'b0);
    host_u.pins.host_reset <= 1'b0;
    repeat (6) @(posedge mclk);
    host_u.pins.display_mem_data <= ~v;
  endtask : hreset

  // Retrace event or clear pulse
  task automatic pulse(input logic clr);
    @(posedge mclk);
    vretrace_evt <= !clr;
    vretrace_clr <= clr;
    @(posedge mclk);
    {vretrace_evt, vretrace_clr} <= 2'b00;
    repeat (4) @(posedge mclk);
  endtask : pulse

  // Verdict and end of run
  task automatic complete_run();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  // Test sequence
  initial
  begin
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    md_drive_req <= 1'b1;
    repeat (2) @(posedge mclk);
    cmp_bit("susp_rst", hw_suspend, 1'b0);
    cmp_word("psave_rst", {29'h0, psave_mode}, 32'h0);
    reg_chk(A_CTRL, 32'h0);
    reg_chk(A_STATUS, {24'h0, ST_IDLE, 3'h0});
    cmp_bit("data_oe", host_data_oe, 1'b0);
    $display("test reset done");
    foreach (mds[i])
    begin
      hreset(mds[i]);
      cmp_bit("md_oe", display_mem_data_oe, 1'b1);
      cmp_word("md_out", {16'h0, display_mem_data_out}, {16'h0, md_wdata});
      reg_chk(A_AUX_CFG, {24'h0, mds[i][12:9], mds[i][3:0]});
      reg_chk(A_STRAPS, {25'h0, mds[i][14:13], mds[i][8:4]});
      apb(1'b0, A_STATUS, 32'h0, rd, er);
      cmp_bit("alatch", rd[2], mds[i][4] & mds[i][5]);
    end
    seq_reset <= 1'b1;
    repeat (3) @(posedge mclk);
    cmp_bit("md_oe_seq", display_mem_data_oe, 1'b0);
    seq_reset <= 1'b0;
    $display("test straps done");
    host_u.cycle(1, IO_B + 24'h1, 16'h3c5a, q, cl, nr);
    cmp_bit("io_wr_claim", cl, 1'b1);
    host_u.cycle(0, IO_B + 24'h1, 16'h0, q, cl, nr);
    cmp_bit("io_rd_claim", cl, 1'b1);
    cmp_word("io_rd", {16'h0, q}, 32'h5a5a);
    cmp_bit("data_oe_idle", host_data_oe, 1'b0);
    cmp_bit("zw_idle", zero_wait_oe, 1'b0);
    host_u.cycle(0, IO_B - 24'h1, 16'h0, q, cl, nr);
    cmp_bit("io_outside", cl, 1'b0);
    host_u.pins.io_decode_gate <= 1'b1;
    host_u.cycle(0, IO_B + 24'h1, 16'h0, q, cl, nr);
    cmp_bit("io_gated", cl, 1'b0);
    host_u.pins.io_decode_gate <= 1'b0;
    $display("test io done");
    for (int w = 0; w <= 6; w += 6)
    begin
      host_u.wait_n = w;
      host_u.cycle(2, MEM_B + 24'h2, 16'h0, q, cl, nr);
      cmp_bit("mem_claim", cl, 1'b1);
      cmp_word("mem_rd", {16'h0, q}, {16'h0, MW});
      cmp_bit("ready_len", nr > w, 1'b1);
      cmp_bit("ready_idle", ready_oe, 1'b0);
      cmp_bit("mem_req_idle", cpu_mem_req, 1'b0);
      cmp_bit("mem_we_rd", cpu_mem_we, 1'b0);
      cmp_word("mem_addr", {8'h0, cpu_mem_addr}, {8'h0, MEM_B + 24'h2});
    end
    host_u.cycle(3, MEM_B, 16'h1234, q, cl, nr);
    cmp_bit("mem_wr_claim", cl, 1'b1);
    cmp_bit("mem_we_wr", cpu_mem_we, 1'b1);
    cmp_word("mem_wr_addr", {8'h0, cpu_mem_addr}, {8'h0, MEM_B});
    cmp_word("mem_wdata", {16'h0, cpu_mem_wdata}, 32'h0034);
    host_u.cycle(2, MEM_L + 24'h1, 16'h0, q, cl, nr);
    cmp_bit("mem_outside", cl, 1'b0);
    host_u.pins.host_refresh_gate <= 1'b0;
    host_u.cycle(2, MEM_B, 16'h0, q, cl, nr);
    cmp_bit("mem_refresh", cl, 1'b0);
    host_u.pins.host_refresh_gate <= 1'b1;
    $display("test memory done");
    apb(1'b1, A_CTRL, 32'h3, rd, er);
    host_u.pins.suspend_n <= 1'b0;
    repeat (5) @(posedge mclk);
    cmp_bit("hw_suspend", hw_suspend, 1'b1);
    cmp_word("psave_susp", {29'h0, psave_mode}, {29'h0, PS_SUSPEND});
    host_u.cycle(1, IO_B + 24'h1, 16'h00c3, q, cl, nr);
    cmp_bit("sus_wr", cl, 1'b0);
    host_u.cycle(0, IO_B + 24'h1, 16'h0, q, cl, nr);
    cmp_bit("sus_rd", cl, 1'b0);
    hreset(16'hffff);
    reg_chk(A_CTRL, 32'h3);
    reg_chk(A_STRAPS, {25'h0, mds[1][14:13], mds[1][8:4]});
    host_u.pins.suspend_n <= 1'b1;
    repeat (5) @(posedge mclk);
    host_u.cycle(0, IO_B + 24'h1, 16'h0, q, cl, nr);
    cmp_word("io_kept", {16'h0, q}, 32'h5a5a);
    $display("test suspend done");
    pulse(1'b0);
    cmp_bit("irq", irq_out, 1'b1);
    cmp_bit("irq_oe", irq_oe, 1'b1);
    repeat (20) @(posedge mclk);
    cmp_bit("irq_held", irq_out, 1'b1);
    pulse(1'b1);
    cmp_bit("irq_clr", irq_out, 1'b0);
    apb(1'b1, A_CTRL, 32'h2, rd, er);
    pulse(1'b0);
    cmp_bit("irq_masked", irq_out, 1'b0);
    apb(1'b1, A_CTRL, 32'h0, rd, er);
    repeat (2) @(posedge mclk);
    cmp_bit("irq_off", irq_oe, 1'b0);
    $display("test interrupt done");
    apb(1'b1, A_CTRL, 32'h0b, rd, er);
    apb(1'b1, 8'h10, 32'h1f, rd, er);
    cmp_bit("wr_err", er, 1'b1);
    apb(1'b0, 8'h10, 32'h0, rd, er);
    cmp_bit("rd_err", er, 1'b1);
    cmp_word("rd_unmapped", rd, 32'h0);
    apb(1'b1, A_AUX_CFG, 32'hff, rd, er);
    reg_chk(A_AUX_CFG, {24'h0, mds[1][12:9], mds[1][3:0]});
    reg_chk(A_CTRL, 32'h0b);
    cmp_word("psave", {29'h0, psave_mode}, 32'h2);
    hreset(16'h0020);
    reg_chk(A_CTRL, 32'h0);
    $display("test registers done");
    complete_run();
  end
endmodule : isa_host_bus_interface_test
